// File: inc/motor_fault_supervisor_defines.vh
`ifndef MOTOR_FAULT_SUPERVISOR_DEFINES_VH
`define MOTOR_FAULT_SUPERVISOR_DEFINES_VH

// register offsets
`define REG_FAULT_STATUS     7'h00
`define REG_PUMP_FAULT_CFG   7'h0B
`define REG_RECOVERY_CFG     7'h0F
`define REG_START_ERR_CFG    7'h10
`define REG_OC_MASK_CFG      7'h12
`define REG_BRAKE_PIN_CFG    7'h13
`define REG_RESTART_CFG      7'h14
`define REG_SPEED_WIN_CFG    7'h15
`define REG_OC_LEVEL_CFG     7'h17

// field positions
`define BIT_PUMP_LOW         5
`define BIT_THERMAL          4
`define BIT_OVERCURRENT      3
`define BIT_OVERSPEED        2
`define BIT_UNDERSPEED       1
`define BIT_STARTUP_FAIL     0
`define BIT_PUMP_FAULT_OFF   1
`define BIT_LATCH_MODE       2
`define BIT_START_ERR_OFF    7
`define BIT_OC_MASK          3
`define BIT_STALL_BRAKE      2
`define BIT_ALERT_INV        1
`define BIT_THERMAL_MASK     0
`define BIT_OC_LEVEL         7
`define FLD_RESTART_HI       7
`define FLD_RESTART_LO       5
`define FLD_OVERSPEED_HI     3
`define FLD_OVERSPEED_LO     2
`define FLD_FORCED_HI        1
`define FLD_FORCED_LO        0

// reset values
`define RESET_REG            8'h00

// timing
`define CLK_HZ               40000000
`define TICK_US              100
`define TICK_CYC             (`CLK_HZ / 1000000 * `TICK_US)
`define TICKS_PER_MS         (1000 / `TICK_US)
`define RESTART_MS_0         0
`define RESTART_MS_1         500
`define RESTART_MS_2         1000
`define RESTART_MS_3         1500
`define RESTART_MS_4         2000
`define RESTART_MS_5         4000
`define RESTART_MS_6         7000
`define RESTART_MS_7         10000
`define OVERSPEED_HZ_0       750
`define OVERSPEED_HZ_1       1500
`define OVERSPEED_HZ_2       3000
`define FORCED_DHZ_0         16
`define FORCED_DHZ_1         32
`define FORCED_DHZ_2         64
`define FORCED_DHZ_3         128
`define START_ROTATIONS      3'd4

`endif

// File: hdl/motor_fault_supervisor.v
`timescale 1ns/1ps
`include "motor_fault_supervisor_defines.vh"

module motor_fault_supervisor #(
  parameter [31:0] TICK_CYC    = `TICK_CYC,
  parameter [31:0] OVS_CYC_0   = `CLK_HZ / `OVERSPEED_HZ_0,
  parameter [31:0] OVS_CYC_1   = `CLK_HZ / `OVERSPEED_HZ_1,
  parameter [31:0] OVS_CYC_2   = `CLK_HZ / `OVERSPEED_HZ_2,
  parameter [31:0] MIN_CYC_0   = (`CLK_HZ * 10) / `FORCED_DHZ_0,
  parameter [31:0] MIN_CYC_1   = (`CLK_HZ * 10) / `FORCED_DHZ_1,
  parameter [31:0] MIN_CYC_2   = (`CLK_HZ * 10) / `FORCED_DHZ_2,
  parameter [31:0] MIN_CYC_3   = (`CLK_HZ * 10) / `FORCED_DHZ_3
) (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       supplyUndervoltage,
  input  wire       overcurrentRaw,
  input  wire       pumpUndervoltage,
  input  wire       overtempRaw,
  input  wire       rotationPulse,
  input  wire       driveActive,
  input  wire       forcedCommutation,
  input  wire       speedZero,
  input  wire       standbyMode,
  input  wire [2:0] gateHighIn,
  input  wire [2:0] gateLowIn,
  input  wire [6:0] regAddr,
  input  wire       regWrEn,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData,
  output reg  [2:0] gateHigh,
  output reg  [2:0] gateLow,
  output reg        gateHiZ,
  output reg        driveHalt,
  output reg        overcurrentRefHalf,
  output wire       alertOut,
  output reg        alertOe
);

  localparam RUN = 1'b0;
  localparam ERR = 1'b1;

  // restart delays in 100 us ticks; kept 32 bits wide, cut to the counter width where used
  localparam [31:0] DLY_0 = `RESTART_MS_0 * `TICKS_PER_MS;
  localparam [31:0] DLY_1 = `RESTART_MS_1 * `TICKS_PER_MS;
  localparam [31:0] DLY_2 = `RESTART_MS_2 * `TICKS_PER_MS;
  localparam [31:0] DLY_3 = `RESTART_MS_3 * `TICKS_PER_MS;
  localparam [31:0] DLY_4 = `RESTART_MS_4 * `TICKS_PER_MS;
  localparam [31:0] DLY_5 = `RESTART_MS_5 * `TICKS_PER_MS;
  localparam [31:0] DLY_6 = `RESTART_MS_6 * `TICKS_PER_MS;
  localparam [31:0] DLY_7 = `RESTART_MS_7 * `TICKS_PER_MS;

  // config registers
  reg [7:0] pumpCfg_r;
  reg [7:0] recoveryCfg_r;
  reg [7:0] startCfg_r;
  reg [7:0] ocMaskCfg_r;
  reg [7:0] brakePinCfg_r;
  reg [7:0] restartCfg_r;
  reg [7:0] speedWinCfg_r;
  reg [7:0] ocLevelCfg_r;

  // pin synchronisers: bit 3 supply_undervoltage, 2 oc, 1 pump, 0 thermal
  reg  [3:0] sync1_r;
  reg  [3:0] sync2_r;
  reg  [3:0] sync3_r;
  reg  [3:0] clean_r;
  wire [3:0] agree = ~(sync2_r ^ sync3_r);
  wire [3:0] clean_nxt = (agree & sync2_r) | (~agree & clean_r);
  wire       supply_undervoltage = clean_r[3];

  reg        state_r;
  reg  [5:0] status_r;
  reg [31:0] periodCnt_r;
  reg        periodValid_r;
  reg  [2:0] forcedRot_r;
  reg [31:0] tickCnt_r;
  reg [16:0] delayCnt_r;
  reg  [2:0] gateHigh_nxt;
  reg  [2:0] gateLow_nxt;

  // enable masks
  wire ocEn    = ~ocMaskCfg_r[`BIT_OC_MASK];
  wire pumpEn  = ~pumpCfg_r[`BIT_PUMP_FAULT_OFF];
  wire thermEn = ~brakePinCfg_r[`BIT_THERMAL_MASK];
  wire startEn = ~startCfg_r[`BIT_START_ERR_OFF];

  wire ocLive    = ocEn & clean_r[2];
  wire pumpLive  = pumpEn & clean_r[1];
  wire thermLive = thermEn & clean_r[0];

  wire [1:0] ovsSel = speedWinCfg_r[`FLD_OVERSPEED_HI:`FLD_OVERSPEED_LO];
  wire [1:0] fstSel = speedWinCfg_r[`FLD_FORCED_HI:`FLD_FORCED_LO];
  wire [2:0] dlySel = restartCfg_r[`FLD_RESTART_HI:`FLD_RESTART_LO];

  reg [31:0] ovsLimit;
  reg [31:0] minLimit;
  reg [16:0] delayTicks;

  // limit lookup
  always @*
  begin
    case (ovsSel)
      2'b00:   ovsLimit = OVS_CYC_0;
      2'b01:   ovsLimit = OVS_CYC_1;
      default: ovsLimit = OVS_CYC_2;
    endcase
    case (fstSel)
      2'b00:   minLimit = MIN_CYC_0;
      2'b01:   minLimit = MIN_CYC_1;
      2'b10:   minLimit = MIN_CYC_2;
      default: minLimit = MIN_CYC_3;
    endcase
    case (dlySel) // restart delay in 100 us ticks
      3'b000:  delayTicks = DLY_0[16:0];
      3'b001:  delayTicks = DLY_1[16:0];
      3'b010:  delayTicks = DLY_2[16:0];
      3'b011:  delayTicks = DLY_3[16:0];
      3'b100:  delayTicks = DLY_4[16:0];
      3'b101:  delayTicks = DLY_5[16:0];
      3'b110:  delayTicks = DLY_6[16:0];
      default: delayTicks = DLY_7[16:0];
    endcase
  end

  // speed events; a locked rotor simply never pulses
  wire [31:0] periodNext = periodCnt_r + 32'd1;
  wire overspeedHit = rotationPulse & periodValid_r & (ovsSel != 2'b11)
                      & (periodNext <= ovsLimit);
  wire underspeedHit = driveActive & ~forcedCommutation
                       & (periodCnt_r > minLimit);
  wire startFailHit = startEn & forcedCommutation & rotationPulse
                      & (forcedRot_r == `START_ROTATIONS - 3'd1);

  wire [5:0] newFaults;
  assign newFaults[`BIT_PUMP_LOW]     = pumpLive;
  assign newFaults[`BIT_THERMAL]      = thermLive;
  assign newFaults[`BIT_OVERCURRENT]  = ocLive;
  assign newFaults[`BIT_OVERSPEED]    = overspeedHit;
  assign newFaults[`BIT_UNDERSPEED]   = underspeedHit;
  assign newFaults[`BIT_STARTUP_FAIL] = startFailHit;

  // clear conditions: analogue faults need their comparator released
  wire clearOk = ~(status_r[`BIT_OVERCURRENT] & ocLive)
                 & ~(status_r[`BIT_PUMP_LOW] & pumpLive)
                 & ~(status_r[`BIT_THERMAL] & thermLive);
  wire releaseEvt = speedZero | standbyMode;
  wire latched = recoveryCfg_r[`BIT_LATCH_MODE];
  wire delayDone = (delayCnt_r >= delayTicks);
  wire resume = clearOk & (releaseEvt | (~latched & delayDone));
  wire freshFault = |(newFaults & ~status_r);

  wire hardFault  = |{status_r[`BIT_PUMP_LOW], status_r[`BIT_THERMAL],
                      status_r[`BIT_OVERCURRENT], status_r[`BIT_OVERSPEED]};
  wire brakeFault = ~hardFault & brakePinCfg_r[`BIT_STALL_BRAKE];
  wire abnormal   = supply_undervoltage | (state_r == ERR);

  // synchronisers; a change counts once stages two and three agree
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      clean_r <= 4'h0;
    end
    else
    begin
      sync1_r <= {supplyUndervoltage, overcurrentRaw, pumpUndervoltage, overtempRaw};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      clean_r <= clean_nxt;
    end
  end

  // register writes; configuration survives undervoltage, only nrst clears it
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pumpCfg_r     <= `RESET_REG;
      recoveryCfg_r <= `RESET_REG;
      startCfg_r    <= `RESET_REG;
      ocMaskCfg_r   <= `RESET_REG;
      brakePinCfg_r <= `RESET_REG;
      restartCfg_r  <= `RESET_REG;
      speedWinCfg_r <= `RESET_REG;
      ocLevelCfg_r  <= `RESET_REG;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        `REG_PUMP_FAULT_CFG: pumpCfg_r     <= regWrData;
        `REG_RECOVERY_CFG:   recoveryCfg_r <= regWrData;
        `REG_START_ERR_CFG:  startCfg_r    <= regWrData;
        `REG_OC_MASK_CFG:    ocMaskCfg_r   <= regWrData;
        `REG_BRAKE_PIN_CFG:  brakePinCfg_r <= regWrData;
        `REG_RESTART_CFG:    restartCfg_r  <= regWrData;
        `REG_SPEED_WIN_CFG:  speedWinCfg_r <= regWrData;
        `REG_OC_LEVEL_CFG:   ocLevelCfg_r  <= regWrData;
        default:             ocLevelCfg_r  <= ocLevelCfg_r;
      endcase
    end
  end

  // register read, one cycle latency; unmapped reads as zero
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else
    begin
      case (regAddr)
        `REG_FAULT_STATUS:   regRdData <= {2'b00, status_r};
        `REG_PUMP_FAULT_CFG: regRdData <= pumpCfg_r;
        `REG_RECOVERY_CFG:   regRdData <= recoveryCfg_r;
        `REG_START_ERR_CFG:  regRdData <= startCfg_r;
        `REG_OC_MASK_CFG:    regRdData <= ocMaskCfg_r;
        `REG_BRAKE_PIN_CFG:  regRdData <= brakePinCfg_r;
        `REG_RESTART_CFG:    regRdData <= restartCfg_r;
        `REG_SPEED_WIN_CFG:  regRdData <= speedWinCfg_r;
        `REG_OC_LEVEL_CFG:   regRdData <= ocLevelCfg_r;
        default:             regRdData <= 8'h00;
      endcase
    end
  end

  // rotation period and forced rotation counting
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      periodCnt_r   <= 32'h0;
      periodValid_r <= 1'b0;
      forcedRot_r   <= 3'h0;
    end
    else if (supply_undervoltage || state_r == ERR || !driveActive)
    begin
      // measurement restarts with every drive attempt
      periodCnt_r   <= 32'h0;
      periodValid_r <= 1'b0;
      forcedRot_r   <= 3'h0;
    end
    else
    begin
      if (rotationPulse)
      begin
        periodCnt_r   <= 32'h0;
        periodValid_r <= 1'b1;
      end
      else if (periodCnt_r != 32'hFFFFFFFF)
        periodCnt_r <= periodCnt_r + 32'd1;
      if (!forcedCommutation)
        forcedRot_r <= 3'h0;
      else if (rotationPulse && forcedRot_r != `START_ROTATIONS)
        forcedRot_r <= forcedRot_r + 3'd1;
    end
  end

  // error mode control; status bits set on entry, accumulate, clear on resume
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r    <= RUN;
      status_r   <= 6'h00;
      tickCnt_r  <= 32'h0;
      delayCnt_r <= 17'h0;
    end
    else if (supply_undervoltage)
    begin
      // undervoltage is a halt, never a reported fault
      state_r    <= RUN;
      status_r   <= 6'h00;
      tickCnt_r  <= 32'h0;
      delayCnt_r <= 17'h0;
    end
    else
    begin
      case (state_r)
        RUN:
        begin
          tickCnt_r  <= 32'h0;
          delayCnt_r <= 17'h0;
          if (|newFaults)
          begin
            state_r  <= ERR;
            status_r <= newFaults;
          end
        end
        ERR:
        begin
          if (tickCnt_r >= TICK_CYC - 32'd1)
          begin
            tickCnt_r <= 32'h0;
            if (!delayDone)
              delayCnt_r <= delayCnt_r + 17'd1;
          end
          else
            tickCnt_r <= tickCnt_r + 32'd1;
          // a fault arriving while resuming wins over the clear
          if (resume && !freshFault)
          begin
            state_r  <= RUN;
            status_r <= 6'h00;
          end
          else
            status_r <= status_r | newFaults;
        end
        default:
          state_r <= RUN;
      endcase
    end
  end

  // gate forcing
  always @*
  begin
    gateHigh_nxt = gateHighIn;
    gateLow_nxt  = gateLowIn;
    if (supply_undervoltage || (state_r == ERR && !brakeFault))
    begin
      gateHigh_nxt = 3'b000;
      gateLow_nxt  = 3'b000;
    end
    else if (state_r == ERR)
    begin
      gateHigh_nxt = 3'b000;  // short brake through low sides
      gateLow_nxt  = 3'b111;
    end
  end

  // registered outputs
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      gateHigh           <= 3'b000;
      gateLow            <= 3'b000;
      gateHiZ            <= 1'b0;
      driveHalt          <= 1'b1;
      overcurrentRefHalf <= 1'b0;
      alertOe            <= 1'b1;
    end
    else
    begin
      gateHigh  <= gateHigh_nxt;
      gateLow   <= gateLow_nxt;
      gateHiZ   <= (state_r == ERR) & status_r[`BIT_PUMP_LOW];
      driveHalt <= abnormal;
      overcurrentRefHalf <= ocLevelCfg_r[`BIT_OC_LEVEL];
      // pin released (reads high) or pulled low per polarity
      alertOe <= abnormal ? brakePinCfg_r[`BIT_ALERT_INV]
                          : ~brakePinCfg_r[`BIT_ALERT_INV];
    end
  end

  assign alertOut = 1'b0;

endmodule

// File: verif/alert_pull_model.sv
`timescale 1ns/1ps
module alert_pull_model (
  input  wire       alertOut,
  input  wire       alertOe,
  input  wire [2:0] gateHigh,
  input  wire [2:0] gateLow,
  output wire       alertPin,
  output wire       shootThrough
);
  // board pull-up owns the line whenever the device lets go
  assign alertPin = alertOe ? alertOut : 1'b1;
  // both switches of one leg on would short the supply rail
  assign shootThrough = |(gateHigh & gateLow);
endmodule

// File: verif/motor_fault_supervisor_sva.sv
`timescale 1ns/1ps
module motor_fault_supervisor_sva (
  input wire       mclk,
  input wire       nrst,
  input wire       supplyUndervoltage,
  input wire [2:0] gateHighIn,
  input wire [6:0] regAddr,
  input wire       regWrEn,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire [2:0] gateHigh,
  input wire [2:0] gateLow,
  input wire       gateHiZ,
  input wire       driveHalt,
  input wire       overcurrentRefHalf
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // halted bridge: high side always off, low side off or braking
  chk_halt_high_off: assert property (driveHalt |-> gateHigh == 3'h0)
    else $error("high side on while halted");
  chk_halt_low_state: assert property (driveHalt |-> gateLow inside {3'h0, 3'h7})
    else $error("low side neither off nor brake while halted");
  chk_float_halted: assert property (gateHiZ |-> driveHalt)
    else $error("outputs floating outside error mode");
  chk_uv_halts: assert property (supplyUndervoltage [*6] |-> driveHalt)
    else $error("undervoltage did not halt");
  // reference select moves only after a write to its register
  chk_ref_on_write: assert property ($changed(overcurrentRefHalf) |->
    $past(regWrEn && regAddr == 7'h17) || $past(regWrEn && regAddr == 7'h17, 2))
    else $error("reference select changed without a write");
  chk_cfg_readback: assert property ((regWrEn && regAddr == 7'h13) ##1
    (regAddr == 7'h13 && !regWrEn) [*2] |=> regRdData == $past(regWrData, 3))
    else $error("pin config read back wrong");
  chk_status_top_zero: assert property (regAddr == 7'h00 |=> regRdData[7:6] == 2'h0)
    else $error("status upper bits set");
  chk_run_follows: assert property (!driveHalt && $past(!driveHalt) |->
    gateHigh == $past(gateHighIn))
    else $error("gates not following commands while running");
endmodule

bind motor_fault_supervisor motor_fault_supervisor_sva u_sva (.mclk, .nrst, .supplyUndervoltage,
  .gateHighIn, .regAddr, .regWrEn, .regWrData, .regRdData, .gateHigh, .gateLow, .gateHiZ,
  .driveHalt, .overcurrentRefHalf);

// File: verif/test_motor_fault_supervisor.sv
`timescale 1ns/1ps
module test_motor_fault_supervisor;
  reg        mclk = 1'b0;
  reg        nrst = 1'b0;
  reg        supplyUndervoltage = 1'b0, overcurrentRaw = 1'b0, pumpUndervoltage = 1'b0;
  reg        overtempRaw = 1'b0, rotationPulse = 1'b0, driveActive = 1'b0;
  reg        forcedCommutation = 1'b0, speedZero = 1'b0, standbyMode = 1'b0;
  reg  [2:0] gateHighIn = 3'h5;
  reg  [2:0] gateLowIn = 3'h2;
  reg  [6:0] regAddr = 7'h00;
  reg        regWrEn = 1'b0;
  reg  [7:0] regWrData = 8'h00;
  wire [7:0] regRdData;
  wire [2:0] gateHigh, gateLow;
  wire       gateHiZ, driveHalt, overcurrentRefHalf, alertOut, alertOe, alertPin, shootThrough;
  integer    errors = 0;
  integer    checked = 0;
  integer    i;
  reg  [7:0] rv;
  localparam [55:0] CFG = {7'h0B, 7'h0F, 7'h10, 7'h12, 7'h13, 7'h14, 7'h15, 7'h17};

  initial forever #12.5 mclk = ~mclk;

  // short counts keep the run small; restart code 001 is 5000 ticks of 4 cycles
  motor_fault_supervisor #(.TICK_CYC(32'd4), .OVS_CYC_0(32'd20), .MIN_CYC_0(32'd200)) dut (
    .mclk, .nrst, .supplyUndervoltage, .overcurrentRaw,
    .pumpUndervoltage, .overtempRaw, .rotationPulse, .driveActive, .forcedCommutation,
    .speedZero, .standbyMode, .gateHighIn, .gateLowIn, .regAddr, .regWrEn, .regWrData,
    .regRdData, .gateHigh, .gateLow, .gateHiZ, .driveHalt, .overcurrentRefHalf, .alertOut,
    .alertOe);
  alert_pull_model far (.alertOut, .alertOe, .gateHigh, .gateLow, .alertPin, .shootThrough);

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bchk(input seen, input exp);
    chk({7'h0, seen}, {7'h0, exp});
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task wt(input [6:0] a, input [7:0] d);
    begin
      @(posedge mclk) regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk) regWrEn <= 1'b0;
    end
  endtask
  // data comes one edge after the address is taken; sample off the edge
  task rd(input [6:0] a);
    begin
      @(posedge mclk) regAddr <= a;
      @(posedge mclk);
      #1 rv = regRdData;
    end
  endtask
  task pulse(input integer gap);
    begin
      cyc(gap);
      rotationPulse <= 1'b1;
      @(posedge mclk) rotationPulse <= 1'b0;
    end
  endtask
  task spin;
    begin
      @(posedge mclk) driveActive <= 1'b1;
      pulse(5);
      pulse(15);
      @(posedge mclk) driveActive <= 1'b0;
      cyc(4);
    end
  endtask
  task err_chk(input [7:0] st, input [7:0] lo, input hiz, input pin);
    begin
      rd(7'h00);
      chk(rv, st);
      chk({5'h0, gateHigh}, 8'h00);
      chk({5'h0, gateLow}, lo);
      bchk(gateHiZ, hiz);
      bchk(driveHalt, 1'b1);
      bchk(alertPin, pin);
    end
  endtask
  task ok;
    begin
      rd(7'h00);
      chk(rv, 8'h00);
      bchk(driveHalt, 1'b0);
      chk({5'h0, gateHigh}, {5'h0, gateHighIn});
      chk({5'h0, gateLow}, {5'h0, gateLowIn});
      bchk(shootThrough, 1'b0);
    end
  endtask
  task final_report;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // watchdog sized well past the code 001 restart wait that the test uses
  initial
  begin
    #(60000 * 25);
    errors = errors + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end

  initial
  begin
    cyc(6);
    bchk(alertOe, 1'b1);
    cyc(6);
    nrst <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      wt(CFG[i * 7 +: 7], 8'hA5);
      rd(CFG[i * 7 +: 7]);
      chk(rv, 8'hA5);
    end
    bchk(overcurrentRefHalf, 1'b1);
    for (i = 0; i < 8; i = i + 1)
      wt(CFG[i * 7 +: 7], 8'h00);
    wt(7'h00, 8'hFF);
    rd(7'h00);
    chk(rv, 8'h00);
    rd(7'h7F);
    chk(rv, 8'h00);
    $display("registers done");
    @(posedge mclk) overcurrentRaw <= 1'b1;
    cyc(8);
    err_chk(8'h08, 8'h00, 1'b0, 1'b1);
    @(posedge mclk) overcurrentRaw <= 1'b0;
    cyc(8);
    ok();
    wt(7'h12, 8'h08);
    @(posedge mclk) overcurrentRaw <= 1'b1;
    cyc(8);
    bchk(driveHalt, 1'b0);
    @(posedge mclk) overcurrentRaw <= 1'b0;
    // unmask only once the comparator level has passed the synchroniser
    cyc(8);
    wt(7'h12, 8'h00);
    @(posedge mclk) pumpUndervoltage <= 1'b1;
    cyc(8);
    err_chk(8'h20, 8'h00, 1'b1, 1'b1);
    @(posedge mclk) pumpUndervoltage <= 1'b0;
    cyc(8);
    ok();
    $display("analog faults done");
    // latched recovery with inverted alert polarity
    wt(7'h0F, 8'h04);
    wt(7'h13, 8'h02);
    @(posedge mclk) overtempRaw <= 1'b1;
    cyc(8);
    err_chk(8'h10, 8'h00, 1'b0, 1'b0);
    @(posedge mclk) overtempRaw <= 1'b0;
    cyc(30);
    err_chk(8'h10, 8'h00, 1'b0, 1'b0);
    @(posedge mclk) speedZero <= 1'b1;
    cyc(3);
    @(posedge mclk) speedZero <= 1'b0;
    cyc(4);
    ok();
    $display("latched done");
    // disabled pass first, then enabled pass with short brake
    for (i = 1; i >= 0; i = i - 1)
    begin
      wt(7'h10, i ? 8'h80 : 8'h00);
      wt(7'h13, 8'h04);
      @(posedge mclk) driveActive <= 1'b1;
      forcedCommutation <= 1'b1;
      repeat (4) pulse(30);
      cyc(4);
      rd(7'h00);
      chk(rv, i ? 8'h00 : 8'h01);
      @(posedge mclk) driveActive <= 1'b0;
      forcedCommutation <= 1'b0;
    end
    err_chk(8'h01, 8'h07, 1'b0, 1'b1);
    @(posedge mclk) standbyMode <= 1'b1;
    cyc(3);
    @(posedge mclk) standbyMode <= 1'b0;
    cyc(4);
    ok();
    wt(7'h13, 8'h00);
    @(posedge mclk) driveActive <= 1'b1;
    cyc(220);
    err_chk(8'h02, 8'h00, 1'b0, 1'b1);
    @(posedge mclk) driveActive <= 1'b0;
    speedZero <= 1'b1;
    cyc(3);
    @(posedge mclk) speedZero <= 1'b0;
    cyc(4);
    ok();
    $display("speed faults done");
    wt(7'h0F, 8'h00);
    wt(7'h15, 8'h0C);
    spin;
    bchk(driveHalt, 1'b0);
    wt(7'h15, 8'h00);
    wt(7'h14, 8'h20);
    spin;
    err_chk(8'h04, 8'h00, 1'b0, 1'b1);
    cyc(18900);
    err_chk(8'h04, 8'h00, 1'b0, 1'b1);
    cyc(1200);
    ok();
    $display("restart delay done");
    @(posedge mclk) supplyUndervoltage <= 1'b1;
    // new commands while halted; they must show once running again
    gateHighIn <= 3'h2;
    gateLowIn <= 3'h1;
    cyc(8);
    err_chk(8'h00, 8'h00, 1'b0, 1'b1);
    @(posedge mclk) supplyUndervoltage <= 1'b0;
    cyc(8);
    ok();
    $display("undervoltage done");
    final_report;
  end
endmodule
